/* File: dss_scan_sequencer.v */
// conversion run sequencer with timer, sample counter and channel memory
`include "dss_consts.vh"
`default_nettype none
module dss_scan_sequencer (
  // clock and reset
  input wire sys_clk_in,
  input wire rstn_in,
  // register port
  input wire [3:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [31:0] rdata_out,
  // trigger pins
  input wire ext_convert_n_in,
  input wire run_trigger_n_in,
  input wire stop_trigger_in,
  input wire ext_timebase_in,
  // converter side
  input wire adc_done_in,
  input wire [11:0] adc_result_in,
  output reg adc_start_out,
  output reg [3:0] mux_channel_out,
  output reg [1:0] gain_out,
  output reg scan_clock_out,
  output reg running_out,
  output reg done_event_out
);
  // control and configuration
  reg [9:0] ctrl;
  reg [15:0] interval;
  reg [31:0] count_load;
  reg [15:0] divide;
  reg [15:0] scan_interval;
  reg [3:0] start_ptr;
  reg [3:0] mux_ptr;
  reg [6:0] mem [0:15];
  // run state
  reg running;
  reg [15:0] itimer;
  reg [31:0] samples;
  reg counting;
  reg [15:0] div_cnt;
  reg [15:0] scan_cnt;
  reg pass_wait;
  reg [6:0] tb_pre;
  reg [2:0] tb_cnt;
  reg [1:0] events;
  reg [1:0] event_en;
  // result buffer
  reg [11:0] fifo [0:511];
  reg [8:0] wr_ptr;
  reg [8:0] rd_ptr;
  reg [9:0] fill;
  // pin synchronisers
  reg [2:0] conv_s;
  reg [2:0] trig_s;
  reg [2:0] stop_s;
  reg [2:0] etb_s;

  // decode one strobe address
  function hit;
    input [3:0] a;
    input [3:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  wire conv_fall = conv_s[2] & ~conv_s[1];
  wire trig_fall = trig_s[2] & ~trig_s[1];
  wire stop_rise = stop_s[1] & ~stop_s[2];
  wire etb_rise = etb_s[1] & ~etb_s[2];
  wire host_conv = wr_in & hit(addr_in, `DSS_A_START_CONV);
  wire run_go = (wr_in & hit(addr_in, `DSS_A_START_RUN)) | trig_fall;
  wire abort = wr_in & hit(addr_in, `DSS_A_CTRL) & wdata_in[`DSS_C_ABORT];
  // timebase select: 1 MHz divided by one to three, or external clock
  wire [1:0] tb_sel = ctrl[`DSS_C_TB_HI-1:`DSS_C_TB_LO];
  wire tb_tick = (tb_sel == 2'h3) ? etb_rise :
                 (tb_pre == 7'h00) && (tb_cnt == 3'h0);
  wire timer_pulse = running & tb_tick & (itimer == 16'h0000);
  wire run_pulse = running & (ctrl[`DSS_C_EXT_CONV] ? conv_fall :
                              timer_pulse);
  wire conv_pulse = run_pulse & ~pass_wait;
  wire single = ~running & (host_conv | conv_fall);
  wire step = ctrl[`DSS_C_SCAN] &
              (~ctrl[`DSS_C_DIVIDE] | (div_cnt == 16'h0000));
  wire last = mem[mux_ptr][6];
  wire fifo_rd = rd_in & hit(addr_in, `DSS_A_FIFO_DATA);
  wire pop = fifo_rd & (fill != 10'h000);
  wire push = adc_done_in & (fill != `DSS_FIFO_DEPTH);
  wire [31:0] samples_dec = samples - 32'h1;
  wire end_now = conv_pulse & counting &
                 (ctrl[`DSS_C_WIDE] ? (samples_dec == 32'h0) :
                  (samples_dec[15:0] == 16'h0));

  // input synchronisers, two flops before any use
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      conv_s <= 3'h7;
      trig_s <= 3'h7;
      stop_s <= 3'h0;
      etb_s <= 3'h0;
    end else begin
      conv_s <= {conv_s[1:0], ext_convert_n_in};
      trig_s <= {trig_s[1:0], run_trigger_n_in};
      stop_s <= {stop_s[1:0], stop_trigger_in};
      etb_s <= {etb_s[1:0], ext_timebase_in};
    end
  end

  // channel memory written through the pointer
  always @(posedge sys_clk_in) begin
    if (wr_in && hit(addr_in, `DSS_A_MEMDATA))
      mem[mux_ptr] <= wdata_in[6:0];
    if (push)
      fifo[wr_ptr] <= adc_result_in;
  end

  // registers, timers and counters
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl <= 10'h000;
      interval <= `DSS_INTERVAL_RST;
      count_load <= 32'h00000000;
      divide <= 16'h0000;
      scan_interval <= 16'h0000;
      start_ptr <= 4'h0;
      mux_ptr <= 4'h0;
      running <= 1'b0;
      itimer <= 16'h0000;
      samples <= 32'h00000000;
      counting <= 1'b0;
      div_cnt <= 16'h0000;
      scan_cnt <= 16'h0000;
      pass_wait <= 1'b0;
      tb_pre <= 7'h00;
      tb_cnt <= 3'h0;
      events <= 2'h0;
      event_en <= 2'h0;
      wr_ptr <= 9'h000;
      rd_ptr <= 9'h000;
      fill <= 10'h000;
      rdata_out <= 32'h00000000;
      adc_start_out <= 1'b0;
      mux_channel_out <= 4'h0;
      gain_out <= 2'h0;
      scan_clock_out <= 1'b0;
      running_out <= 1'b0;
      done_event_out <= 1'b0;
    end else begin
      // 125 MHz to 1 MHz, then divide by tb_sel plus one
      tb_pre <= (tb_pre == 7'h00) ? `DSS_TB_1MHZ : tb_pre - 7'h01;
      if (tb_pre == 7'h00)
        tb_cnt <= (tb_cnt == 3'h0) ? {1'b0, tb_sel} : tb_cnt - 3'h1;
      if (wr_in) begin
        case (addr_in)
          `DSS_A_CTRL: ctrl <= {1'b0, wdata_in[8:0]};
          `DSS_A_INTERVAL: interval <= wdata_in[15:0];
          `DSS_A_COUNT_LO: count_load[15:0] <= wdata_in[15:0];
          `DSS_A_COUNT_HI: count_load[31:16] <= wdata_in[15:0];
          `DSS_A_DIVIDE: divide <= wdata_in[15:0];
          `DSS_A_SCAN_INT: scan_interval <= wdata_in[15:0];
          `DSS_A_EVENTS: event_en <= wdata_in[3:2];
          default: ;
        endcase
      end
      if (wr_in && hit(addr_in, `DSS_A_MUXPTR)) begin
        mux_ptr <= wdata_in[3:0];
        start_ptr <= wdata_in[3:0];
      end else if (wr_in && hit(addr_in, `DSS_A_MEMDATA) && !running) begin
        mux_ptr <= mux_ptr + 4'h1;
      end else if (conv_pulse && ctrl[`DSS_C_SCAN]) begin
        if (ctrl[`DSS_C_DIVIDE])
          div_cnt <= (div_cnt == 16'h0000) ? divide - 16'h1 :
                     div_cnt - 16'h1;
        if (step)
          mux_ptr <= last ? start_ptr : mux_ptr + 4'h1;
      end
      if (running && tb_tick)
        itimer <= (itimer == 16'h0000) ? interval - 16'h1 :
                  itimer - 16'h1;
      if (running && ctrl[`DSS_C_INTERVAL_SCAN] && tb_tick)
        scan_cnt <= (scan_cnt == 16'h0000) ? scan_interval - 16'h1 :
                    scan_cnt - 16'h1;
      if (running && ctrl[`DSS_C_INTERVAL_SCAN] && tb_tick &&
          scan_cnt == 16'h0000)
        pass_wait <= 1'b0;
      else if (conv_pulse && step && last && ctrl[`DSS_C_INTERVAL_SCAN])
        pass_wait <= 1'b1;
      if (running && !counting && stop_rise)
        counting <= 1'b1;
      if (conv_pulse && counting)
        samples <= ctrl[`DSS_C_WIDE] ? samples_dec :
                   {16'h0000, samples_dec[15:0]};
      if (run_go && !running) begin
        running <= 1'b1;
        itimer <= interval - 16'h1;
        samples <= count_load;
        counting <= ~ctrl[`DSS_C_STOP_TRIGGER_IN];
        div_cnt <= divide - 16'h1;
        scan_cnt <= scan_interval - 16'h1;
        pass_wait <= 1'b0;
        mux_ptr <= start_ptr;
      end else if (end_now || abort) begin
        running <= 1'b0;
      end
      // done event, overflow; set wins over clear
      events <= (events & ~((wr_in && hit(addr_in, `DSS_A_EVENTS)) ?
                 wdata_in[1:0] : 2'h0)) |
                {adc_done_in & (fill == `DSS_FIFO_DEPTH), end_now};
      if (push)
        wr_ptr <= wr_ptr + 9'h001;
      if (pop)
        rd_ptr <= rd_ptr + 9'h001;
      fill <= fill + {9'h000, push} - {9'h000, pop};
      // read data, one cycle later
      rdata_out <= 32'h00000000;
      if (rd_in) begin
        case (addr_in)
          `DSS_A_CTRL: rdata_out <= {22'h0, ctrl};
          `DSS_A_INTERVAL: rdata_out <= {16'h0, interval};
          `DSS_A_COUNT_LO: rdata_out <= {16'h0, samples[15:0]};
          `DSS_A_COUNT_HI: rdata_out <= {16'h0, samples[31:16]};
          `DSS_A_DIVIDE: rdata_out <= {16'h0, divide};
          `DSS_A_SCAN_INT: rdata_out <= {16'h0, scan_interval};
          `DSS_A_MUXPTR: rdata_out <= {28'h0, mux_ptr};
          `DSS_A_MEMDATA: rdata_out <= {25'h0, mem[mux_ptr]};
          `DSS_A_STATUS: rdata_out <= {20'h0, fill, pass_wait,
                                       counting};
          `DSS_A_EVENTS: rdata_out <= {28'h0, event_en, events};
          `DSS_A_FIFO_DATA: rdata_out <= {20'h0, fifo[rd_ptr]};
          default: rdata_out <= 32'h00000000;
        endcase
      end
      adc_start_out <= single | conv_pulse;
      scan_clock_out <= conv_pulse;
      mux_channel_out <= mem[mux_ptr][3:0];
      gain_out <= mem[mux_ptr][5:4];
      running_out <= running;
      done_event_out <= |(events & event_en);
    end
  end
endmodule
`default_nettype wire

/* File: dss_consts.vh */
// constants for the scan sequencer: addresses, fields, reset values
`ifndef DSS_CONSTS_VH
`define DSS_CONSTS_VH
`define DSS_A_CTRL 4'h0
`define DSS_A_INTERVAL 4'h1
`define DSS_A_COUNT_LO 4'h2
`define DSS_A_COUNT_HI 4'h3
`define DSS_A_DIVIDE 4'h4
`define DSS_A_SCAN_INT 4'h5
`define DSS_A_MUXPTR 4'h6
`define DSS_A_MEMDATA 4'h7
`define DSS_A_START_CONV 4'h8
`define DSS_A_START_RUN 4'h9
`define DSS_A_STATUS 4'hA
`define DSS_A_EVENTS 4'hB
`define DSS_A_FIFO_DATA 4'hC
`define DSS_C_SCAN 0
`define DSS_C_INTERVAL_SCAN 1
`define DSS_C_WIDE 2
`define DSS_C_STOP_TRIGGER_IN 3
`define DSS_C_DIVIDE 4
`define DSS_C_EXT_CONV 5
`define DSS_C_TB_LO 6
`define DSS_C_TB_HI 8
`define DSS_C_ABORT 9
`define DSS_EV_DONE 0
`define DSS_EV_OVERFLOW 1
`define DSS_INTERVAL_RST 16'h0002
`define DSS_FIFO_DEPTH 10'h200
`define DSS_TB_1MHZ 7'h7C
`endif

/* File: dss_scan_sequencer_props.sv */
// port assertions for the scan sequencer
`default_nettype none
module dss_checker (
  // watched ports
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [3:0] addr_in,
  input wire logic wr_in,
  input wire logic ext_convert_n_in,
  input wire logic run_trigger_n_in,
  input wire logic adc_start_out,
  input wire logic [3:0] mux_channel_out,
  input wire logic scan_clock_out,
  input wire logic running_out,
  input wire logic done_event_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);
  // start causes, pulse shapes and pointer motion
  conv_write_a: assert property (
    wr_in && addr_in == 4'h8 && !running_out |=> adc_start_out)
    else $error("host convert lost");
  conv_pin_a: assert property (
    $fell(ext_convert_n_in) && !running_out |-> ##[1:6] adc_start_out)
    else $error("pin convert lost");
  run_write_a: assert property (
    wr_in && addr_in == 4'h9 |=> ##1 running_out)
    else $error("host run lost");
  run_pin_a: assert property (
    $fell(run_trigger_n_in) |-> ##[1:6] running_out) else $error("pin run");
  conv_pulse_a: assert property (
    adc_start_out |=> !adc_start_out) else $error("long convert pulse");
  scan_pulse_a: assert property (
    scan_clock_out |-> running_out ##1 !scan_clock_out)
    else $error("bad scan clock");
  mux_step_a: assert property (
    running_out && $past(running_out) && $changed(mux_channel_out) |->
    $past(scan_clock_out) || $past(scan_clock_out, 2)
    || $past(scan_clock_out, 3)) else $error("pointer moved alone");
  done_idle_a: assert property (
    $rose(done_event_out) |-> !running_out) else $error("early done");
endmodule
bind dss_scan_sequencer dss_checker u_dss_checker (.sys_clk_in,
  .rstn_in, .addr_in, .wr_in, .ext_convert_n_in, .run_trigger_n_in,
  .adc_start_out, .mux_channel_out, .scan_clock_out, .running_out,
  .done_event_out);
`default_nettype wire

/* File: dss_adc_model.sv */
// converter model answering each start after a short or long delay
`default_nettype none
module dss_adc_model (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // converter handshake
  input wire logic start_in,
  input wire logic slow_in,
  output logic done_out,
  output logic [11:0] result_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] wait_cnt;
  logic [11:0] sample;
  // count the conversion time, then hand over one result
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wait_cnt <= 6'h0;
      done_out <= 1'b0;
      sample <= 12'h5A0;
    end else begin
      done_out <= (wait_cnt == 6'h1);
      if (done_out) sample <= sample + 12'h1;
      if (start_in) wait_cnt <= slow_in ? 6'h28 : 6'h2;
      else if (wait_cnt != 6'h0) wait_cnt <= wait_cnt - 6'h1;
    end
  end
  // data lines are not held once the result is gone
  assign result_out = done_out ? sample : ~sample;
endmodule
`default_nettype wire

/* File: test_daq_scan_sequencer.sv */
// testbench for the scan sequencer with a converter model
`include "dss_consts.vh"
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  err_total++; $display("unexpected at %0t: %0h vs %0h", $time, g, e); \
  end end
module test_daq_scan_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [31:0] ctrl; logic [3:0] n; logic [31:0] seq;
    logic trig; logic stop; logic lg;} dss_row_t;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, ecn = 1, rtn = 1, stp = 0;
  logic slow = 0, etb = 0, adone, astart, scan, run, dev;
  logic [3:0] addr = 0, mux;
  logic [1:0] gain;
  logic [11:0] ares;
  logic [31:0] wdata = 0, rdata, v;
  int err_total = 0, check_count = 0, cyc = 0;
  // control word, count, four channel/gain bytes, pin start, stop, gap
  dss_row_t rows [6] = '{
    '{32'h00, 4'h4, 32'h13131313, 0, 0, 0},
    '{32'h01, 4'h4, 32'h13191513, 0, 0, 0},
    '{32'h11, 4'h4, 32'h15151313, 0, 0, 0},
    '{32'h05, 4'h4, 32'h13191513, 1, 0, 0},
    '{32'h03, 4'h4, 32'h13191513, 0, 0, 1},
    '{32'h08, 4'h2, 32'h13131313, 0, 1, 0}};
  dss_scan_sequencer u_dss_scan_sequencer (.sys_clk_in(clk), .rstn_in(rstn),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .ext_convert_n_in(ecn), .run_trigger_n_in(rtn),
    .stop_trigger_in(stp), .ext_timebase_in(etb), .adc_done_in(adone),
    .adc_result_in(ares), .adc_start_out(astart), .mux_channel_out(mux),
    .gain_out(gain), .scan_clock_out(scan), .running_out(run),
    .done_event_out(dev));
  dss_adc_model u_dss_adc_model (.sys_clk_in(clk), .rstn_in(rstn),
    .start_in(astart), .slow_in(slow), .done_out(adone), .result_out(ares));
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [3:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask
  // one run: log channel/gain of the first four conversions and the widest gap
  task automatic do_row(input dss_row_t r);
    int k, n = 0, gap = 0, mx = 0;
    logic [31:0] got = 0;
    wreg(`DSS_A_MUXPTR, 32'h0);
    wreg(`DSS_A_CTRL, r.ctrl);
    wreg(`DSS_A_COUNT_LO, {28'h0, r.n});
    if (r.trig) begin
      rtn <= 1'b0;
      repeat (4) @(posedge clk);
      rtn <= 1'b1;
    end else wreg(`DSS_A_START_RUN, 32'h0);
    for (k = 0; k < 20000 && (run || k < 8); k++) begin
      @(posedge clk);
      gap++;
      if (astart) begin
        if (n < 4) got[8*n +: 8] = {2'h0, gain, mux};
        if (n > 0 && gap > mx) mx = gap;
        n++;
        gap = 0;
        if (r.stop && n == 3) stp <= 1'b1;
      end
    end
    @(posedge clk);
    `CHK(n, r.n + (r.stop ? 3 : 0))
    `CHK(got, r.seq)
    `CHK(mx > 2000, r.lg)
    `CHK(dev, 1'b1)
    wreg(`DSS_A_EVENTS, 32'h5);
    stp <= 1'b0;
  endtask
  task tally_and_finish();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // reset, memory, single conversions, overflow, then the run table
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    `CHK({run, dev, scan, astart, rdata}, 36'h0)
    wreg(`DSS_A_MUXPTR, 32'h0);
    wreg(`DSS_A_MEMDATA, 32'h13);
    wreg(`DSS_A_MEMDATA, 32'h15);
    wreg(`DSS_A_MEMDATA, 32'h59);
    wreg(`DSS_A_MUXPTR, 32'h2);
    repeat (2) @(posedge clk);
    `CHK({gain, mux}, 6'h19)
    wreg(`DSS_A_START_CONV, 32'h0);
    repeat (4) @(posedge clk);
    rreg(`DSS_A_FIFO_DATA);
    `CHK(v, 32'h5A0)
    ecn <= 1'b0;
    repeat (4) @(posedge clk);
    ecn <= 1'b1;
    repeat (8) @(posedge clk);
    rreg(`DSS_A_FIFO_DATA);
    `CHK(v, 32'h5A1)
    rreg(4'hD);
    `CHK(v, 32'h0)
    repeat (513) begin
      wreg(`DSS_A_START_CONV, 32'h0);
      repeat (2) @(posedge clk);
    end
    rreg(`DSS_A_STATUS);
    `CHK(v[11:2], `DSS_FIFO_DEPTH)
    rreg(`DSS_A_EVENTS);
    `CHK(v[1], 1'b1)
    wreg(`DSS_A_EVENTS, 32'h7);
    wreg(`DSS_A_DIVIDE, 32'h2);
    wreg(`DSS_A_SCAN_INT, 32'h14);
    // runs pace at 10 us, slow converter from here on
    wreg(`DSS_A_INTERVAL, 32'hA);
    slow <= 1'b1;
    foreach (rows[i]) do_row(rows[i]);
    // external pulse train alone paces a run
    wreg(`DSS_A_CTRL, 32'h20);
    wreg(`DSS_A_COUNT_LO, 32'h2);
    wreg(`DSS_A_START_RUN, 32'h0);
    repeat (1300) @(posedge clk);
    `CHK(run, 1'b1)
    repeat (2) begin
      ecn <= 1'b0;
      repeat (4) @(posedge clk);
      ecn <= 1'b1;
      repeat (1250) @(posedge clk);
    end
    `CHK(run, 1'b0)
    // external timebase drives the interval timer
    wreg(`DSS_A_CTRL, 32'hC0);
    wreg(`DSS_A_COUNT_LO, 32'h1);
    wreg(`DSS_A_START_RUN, 32'h0);
    repeat (1300) @(posedge clk);
    `CHK(run, 1'b1)
    repeat (12) begin
      etb <= 1'b1;
      repeat (4) @(posedge clk);
      etb <= 1'b0;
      repeat (4) @(posedge clk);
    end
    `CHK(run, 1'b0)
    // abort bit stops a run at once
    wreg(`DSS_A_START_RUN, 32'h0);
    wreg(`DSS_A_CTRL, 32'h200);
    @(posedge clk);
    `CHK(run, 1'b0)
    tally_and_finish();
  end
endmodule
`default_nettype wire
